/* File: rtl/ioie_core.v */
// Inclusive-OR and increment-skip executor with four-phase sequencer and Wishbone registers
//
// Our own choices: the address map and register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
`include "ioie_defines.vh"

module ioie_core (
  // Clock and reset
  input wire i_ref_clk,
  input wire i_rst,
  // Wishbone classic slave
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [7:0] i_wb_adr,
  input wire [31:0] i_wb_dat,
  input wire [3:0] i_wb_sel,
  output reg [31:0] o_wb_dat,
  output reg o_wb_ack,
  // Core status
  output wire o_busy
);

  // Instruction phases
  localparam PH_Q1 = 2'd0;
  localparam PH_Q2 = 2'd1;
  localparam PH_Q3 = 2'd2;
  localparam PH_Q4 = 2'd3;

  // Software visible state
  reg ctrl_ext_q;
  reg [15:0] ir_q;
  reg [15:0] next_q;
  reg [7:0] w_q;
  reg [4:0] status_q;
  reg [3:0] bank_select_register_q;
  reg [11:0] index_base_q;
  reg [20:0] pc_q;
  reg [11:0] maddr_q;

  // Sequencer state
  reg busy_q;
  reg [1:0] phase_q;
  reg skipping_q;
  reg [1:0] nop_left_q;
  reg [11:0] ea_q;
  reg [7:0] opnd_q;
  reg [7:0] res_q;

  // Data memory, 16 banks of 256 bytes
  reg [7:0] mem [0:4095];

  // Decode of the instruction register
  wire dec_or_literal_into_accumulator;
  wire dec_or_accumulator_with_file;
  wire dec_increment_skip_if_nonzero;
  wire dst_file;
  wire bank_bit;
  wire [7:0] faddr;
  wire use_indexed;
  wire [11:0] ea_d;
  wire [7:0] res_d;
  wire next_two_word;
  wire skip_taken;
  wire [20:0] pc_step;
  wire exec_q4;
  wire core_mem_we;

  // Bus side helpers
  wire wb_req;
  wire wb_wr_idle;
  wire [31:0] wmask;
  reg [31:0] rd_mux;

  assign o_busy = busy_q;

  assign dec_or_literal_into_accumulator = (ir_q[15:8] == `IOIE_OP_ORLIT);
  assign dec_or_accumulator_with_file = (ir_q[15:10] == `IOIE_OP_ORFILE);
  assign dec_increment_skip_if_nonzero = (ir_q[15:10] == `IOIE_OP_INCSNZ);
  assign dst_file = ir_q[9];
  assign bank_bit = ir_q[8];
  assign faddr = ir_q[7:0];

  assign use_indexed = ctrl_ext_q & ~bank_bit & (faddr <= `IOIE_IDX_LIMIT);

  // bank or access bank address
  // Access bank offsets from 0x60 up land in the special-function bank
  assign ea_d = bank_bit ? {bank_select_register_q, faddr} :
                use_indexed ? (index_base_q + {4'h0, faddr}) :
                (faddr < `IOIE_ACC_SPLIT) ? {4'h0, faddr} :
                {`IOIE_SFR_BANK, faddr};

  // OR datapath, increment for the skip instruction
  assign res_d = (dec_or_literal_into_accumulator | dec_or_accumulator_with_file) ?
                 (w_q | opnd_q) :
                 dec_increment_skip_if_nonzero ? (opnd_q + 8'h01) : opnd_q;

  // Length of the instruction that follows, for the skip cost
  assign next_two_word = (next_q[15:12] == `IOIE_OP_2W_MOVE) |
                         (next_q[15:10] == `IOIE_OP_2W_LONG) |
                         (next_q[15:8] == `IOIE_OP_2W_GOTO);

  assign skip_taken = dec_increment_skip_if_nonzero & (res_q != 8'h00);
  assign pc_step = skip_taken ?
                   (`IOIE_PC_WORD + (next_two_word ? `IOIE_PC_TWO_WORDS : `IOIE_PC_WORD)) :
                   `IOIE_PC_WORD;

  assign exec_q4 = busy_q & ~skipping_q & (phase_q == PH_Q4);
  // write back to file when destination bit set
  assign core_mem_we = exec_q4 & dst_file &
                       (dec_or_accumulator_with_file | dec_increment_skip_if_nonzero);

  // Bus request decode; ack drops in the cycle after it was given
  assign wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  // Writes are only taken while idle so software never races the sequencer
  assign wb_wr_idle = wb_req & i_wb_we & ~busy_q;
  assign wmask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};

  // Byte-lane merge of bus write data into an old value
  function [31:0] merge;
    input [31:0] old;
    begin
      merge = (old & ~wmask) | (i_wb_dat & wmask);
    end
  endfunction

  // Merged write words; a part-select of a function call is not legal Verilog
  wire [31:0] m_ctrl = merge({31'h00000000, ctrl_ext_q});
  wire [31:0] m_ir = merge({16'h0000, ir_q});
  wire [31:0] m_next = merge({16'h0000, next_q});
  wire [31:0] m_w = merge({24'h000000, w_q});
  wire [31:0] m_st = merge({27'h0000000, status_q});
  wire [31:0] m_bank = merge({28'h0000000, bank_select_register_q});
  wire [31:0] m_idx = merge({20'h00000, index_base_q});
  wire [31:0] m_pc = merge({11'h000, pc_q});
  wire [31:0] m_maddr = merge({20'h00000, maddr_q});

  // Read data mux, unmapped offsets read zero
  always @* begin
    rd_mux = 32'h00000000;
    case (i_wb_adr)
      `IOIE_ADR_CTRL: rd_mux = {31'h00000000, ctrl_ext_q};
      `IOIE_ADR_INSTR: rd_mux = {16'h0000, ir_q};
      `IOIE_ADR_NEXT: rd_mux = {16'h0000, next_q};
      `IOIE_ADR_ACC: rd_mux = {24'h000000, w_q};
      `IOIE_ADR_STATUS: rd_mux = {27'h0000000, status_q};
      `IOIE_ADR_BANK: rd_mux = {28'h0000000, bank_select_register_q};
      `IOIE_ADR_INDEX: rd_mux = {20'h00000, index_base_q};
      `IOIE_ADR_PC: rd_mux = {11'h000, pc_q};
      `IOIE_ADR_STATE: rd_mux = {26'h000000, nop_left_q, skipping_q, phase_q, busy_q};
      `IOIE_ADR_MADDR: rd_mux = {20'h00000, maddr_q};
      `IOIE_ADR_MDATA: rd_mux = {24'h000000, mem[maddr_q]};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Data memory port; core write in Q4 beats the bus, which is blocked while busy anyway
  always @(posedge i_ref_clk) begin
    if (core_mem_we) begin
      mem[ea_q] <= res_q;
    end else if (wb_wr_idle && (i_wb_adr == `IOIE_ADR_MDATA) && i_wb_sel[0]) begin
      mem[maddr_q] <= i_wb_dat[7:0];
    end
  end

  // Bus slave and four-phase sequencer
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
      ctrl_ext_q <= 1'b0;
      ir_q <= 16'h0000;
      next_q <= 16'h0000;
      w_q <= `IOIE_RST_ACC;
      status_q <= `IOIE_RST_STATUS;
      bank_select_register_q <= `IOIE_RST_BANK;
      index_base_q <= `IOIE_RST_INDEX;
      pc_q <= `IOIE_RST_PC;
      maddr_q <= 12'h000;
      busy_q <= 1'b0;
      phase_q <= PH_Q1;
      skipping_q <= 1'b0;
      nop_left_q <= 2'd0;
      ea_q <= 12'h000;
      opnd_q <= 8'h00;
      res_q <= 8'h00;
    end else begin
      o_wb_ack <= wb_req;
      if (wb_req) begin
        o_wb_dat <= rd_mux;
      end
      // Register writes from software
      if (wb_wr_idle) begin
        case (i_wb_adr)
          `IOIE_ADR_CTRL: ctrl_ext_q <= m_ctrl[`IOIE_CTRL_EXT];
          `IOIE_ADR_INSTR: begin
            // one word, one cycle unless a skip adds no-ops
            ir_q <= m_ir[15:0];
            busy_q <= 1'b1;
            phase_q <= PH_Q1;
            skipping_q <= 1'b0;
          end
          `IOIE_ADR_NEXT: next_q <= m_next[15:0];
          `IOIE_ADR_ACC: w_q <= m_w[7:0];
          `IOIE_ADR_STATUS: status_q <= m_st[4:0];
          `IOIE_ADR_BANK: bank_select_register_q <= m_bank[3:0];
          `IOIE_ADR_INDEX: index_base_q <= m_idx[11:0];
          `IOIE_ADR_PC: pc_q <= m_pc[20:0];
          `IOIE_ADR_MADDR: maddr_q <= m_maddr[11:0];
          default: ;
        endcase
      end
      if (busy_q) begin
        phase_q <= phase_q + 2'd1;
        case (phase_q)
          PH_Q1: begin
            ea_q <= ea_d;
          end
          PH_Q2: begin
            // literal or file read in Q2
            opnd_q <= dec_or_literal_into_accumulator ? ir_q[7:0] : mem[ea_q];
          end
          PH_Q3: begin
            res_q <= res_d;
          end
          PH_Q4: begin
            if (skipping_q) begin
              // discarded instruction runs as no-op cycles
              nop_left_q <= nop_left_q - 2'd1;
              if (nop_left_q == 2'd1) begin
                busy_q <= 1'b0;
                skipping_q <= 1'b0;
              end
            end else begin
              // result to accumulator when destination bit clear
              if (dec_or_literal_into_accumulator ||
                  ((dec_or_accumulator_with_file || dec_increment_skip_if_nonzero) && !dst_file)) begin
                w_q <= res_q;
              end
              if (dec_or_literal_into_accumulator || dec_or_accumulator_with_file) begin
                status_q[`IOIE_ST_N] <= res_q[7];
                status_q[`IOIE_ST_Z] <= (res_q == 8'h00);
              end
              // program counter past or onto next
              pc_q <= pc_q + pc_step;
              // two or three cycles on skip
              if (skip_taken) begin
                skipping_q <= 1'b1;
                nop_left_q <= next_two_word ? 2'd2 : 2'd1;
              end else begin
                busy_q <= 1'b0;
              end
            end
          end
          default: ;
        endcase
      end
    end
  end

endmodule // ioie_core
`default_nettype wire

/* File: rtl/ioie_defines.vh */
// Constants for the inclusive-OR instruction execution block
// Operation
// - Upper opcode byte 0000 1001 ORs the accumulator with the low-byte literal into the accumulator.
// - Both OR instructions change only the negative and zero flags and take one word and one cycle.
// - Literal OR decodes in Q1, takes the literal in Q2, computes in Q3 and writes W in Q4.
// - Opcode 0001 00 d a f ORs the accumulator with the addressed file register.
// - Destination bit 0 sends the file OR result to W, 1 writes it back to the file register.
// - Bank bit 0 targets the access bank, 1 takes the bank from the bank select register.
// - With the extended set on, bank bit 0 and address up to 95, addressing is indexed literal offset.
// - File OR decodes in Q1, reads the file in Q2, computes in Q3 and writes the destination in Q4.
// - After increment-and-skip a nonzero result passes over the next instruction, zero continues.
// - A skip discards the fetched next instruction as a no-op cycle, two for a two-word one.
`ifndef IOIE_DEFINES_VH
`define IOIE_DEFINES_VH

// Register byte offsets on the Wishbone bus
`define IOIE_ADR_CTRL 8'h00
`define IOIE_ADR_INSTR 8'h04
`define IOIE_ADR_NEXT 8'h08
`define IOIE_ADR_ACC 8'h0c
`define IOIE_ADR_STATUS 8'h10
`define IOIE_ADR_BANK 8'h14
`define IOIE_ADR_INDEX 8'h18
`define IOIE_ADR_PC 8'h1c
`define IOIE_ADR_STATE 8'h20
`define IOIE_ADR_MADDR 8'h24
`define IOIE_ADR_MDATA 8'h28

// Field positions
`define IOIE_CTRL_EXT 0
`define IOIE_ST_Z 2
`define IOIE_ST_N 4

// Reset values
`define IOIE_RST_PC 21'h000000
`define IOIE_RST_ACC 8'h00
`define IOIE_RST_STATUS 5'h00
`define IOIE_RST_BANK 4'h0
`define IOIE_RST_INDEX 12'h000

// Opcode fields
`define IOIE_OP_ORLIT 8'h09
`define IOIE_OP_ORFILE 6'h04
`define IOIE_OP_INCSNZ 6'h12
`define IOIE_OP_2W_MOVE 4'hc
`define IOIE_OP_2W_LONG 6'h3b
`define IOIE_OP_2W_GOTO 8'hef

// Addressing
`define IOIE_IDX_LIMIT 8'h5f
`define IOIE_ACC_SPLIT 8'h60
`define IOIE_SFR_BANK 4'hf

// Program counter steps in bytes
`define IOIE_PC_WORD 21'h000002
`define IOIE_PC_TWO_WORDS 21'h000004

`endif

/* File: tb/ioie_core_sva.sv */
// Bus and sequencing checks for the inclusive-OR executor
`timescale 1ns/10ps
`default_nettype none
module ioie_core_sva (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Bus request
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  // Bus answer and status
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire logic o_busy
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // A request not yet answered
  wire take = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  logic [4:0] busy_n_q;
  // Busy length; saturates so a hang still shows
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || !o_busy) busy_n_q <= 5'h00;
    else if (busy_n_q != 5'h1f) busy_n_q <= busy_n_q + 5'h01;
  end
  chk_ack_follows: assert property (take |=> o_wb_ack) else $error("ack late");
  chk_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack held");
  chk_ack_cause: assert property (o_wb_ack |-> $past(i_wb_cyc & i_wb_stb))
    else $error("ack without request");
  chk_busy_cause: assert property ($rose(o_busy) |-> $past(take && i_wb_we && i_wb_adr == 8'h04))
    else $error("busy without start");
  chk_busy_start: assert property (take && i_wb_we && i_wb_adr == 8'h04 && !o_busy |=> o_busy)
    else $error("start missed");
  chk_busy_phases: assert property ($rose(o_busy) |-> o_busy [*4])
    else $error("cycle shorter than four phases");
  chk_busy_len: assert property ($fell(o_busy) |-> busy_n_q inside {5'h04, 5'h08, 5'h0c})
    else $error("busy length wrong");
  chk_skip_bound: assert property (o_busy |-> busy_n_q < 5'h0c)
    else $error("busy too long");
  chk_state_read: assert property (take && !i_wb_we && i_wb_adr == 8'h20
    |=> o_wb_dat[0] == $past(o_busy) && o_wb_dat[31:6] == 26'h0) else $error("state wrong");
  chk_unmapped_zero: assert property (take && !i_wb_we && i_wb_adr == 8'h30 |=> o_wb_dat == 32'h0)
    else $error("unmapped not zero");
  chk_dat_hold: assert property (!o_wb_ack |-> $stable(o_wb_dat)) else $error("data moved");
endmodule // ioie_core_sva

bind ioie_core ioie_core_sva u_ioie_core_sva (.i_ref_clk, .i_rst, .i_wb_cyc, .i_wb_stb,
  .i_wb_we, .i_wb_adr, .o_wb_dat, .o_wb_ack, .o_busy);
`default_nettype wire

/* File: tb/tb_ioie_core.sv */
// Self-checking bench for the inclusive-OR executor
`timescale 1ns/10ps
`default_nettype none
`include "ioie_defines.vh"
module tb_ioie_core;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_wb_cyc = 1'b0;
  logic i_wb_stb = 1'b0;
  logic i_wb_we = 1'b0;
  logic [7:0] i_wb_adr = 8'h00;
  logic [31:0] i_wb_dat = 32'h0;
  logic [3:0] i_wb_sel = 4'hf;
  logic [31:0] o_wb_dat;
  logic o_wb_ack;
  logic o_busy;
  logic [31:0] rv;
  int n_fail = 0;
  int n_checks = 0;

  ioie_core u_ioie_core (.i_ref_clk, .i_rst, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
    .i_wb_dat, .i_wb_sel, .o_wb_dat, .o_wb_ack, .o_busy);

  // 25 MHz reference clock
  always #20 i_ref_clk = ~i_ref_clk;

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Idle edge first, so cyc stays low a cycle between requests
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge i_ref_clk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= we;
    i_wb_adr <= a;
    i_wb_dat <= d;
    do begin
      @(posedge i_ref_clk);
      t++;
    end while (o_wb_ack !== 1'b1 && t < 20);
    chk("ack", o_wb_ack, 32'h1);
    rv = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    i_wb_we <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, rv, e);
  endtask

  // Start an instruction and count its busy cycles
  task automatic ex(input logic [31:0] ins, input int n_exp);
    int n;
    n = 0;
    bus(1'b1, `IOIE_ADR_INSTR, ins);
    while (o_busy === 1'b1 && n < 40) begin
      @(posedge i_ref_clk);
      n++;
    end
    chk("cycles", 32'(n), 32'(n_exp));
  endtask

  task automatic orf(input logic [31:0] ext, ma, md, w, ins, em, ew);
    bus(1'b1, `IOIE_ADR_CTRL, ext);
    bus(1'b1, `IOIE_ADR_BANK, 32'h3);
    bus(1'b1, `IOIE_ADR_INDEX, 32'h200);
    bus(1'b1, `IOIE_ADR_MADDR, ma);
    bus(1'b1, `IOIE_ADR_MDATA, md);
    bus(1'b1, `IOIE_ADR_ACC, w);
    ex(ins, 4);
    rdc(`IOIE_ADR_MDATA, em, "file");
    rdc(`IOIE_ADR_ACC, ew, "acc");
  endtask

  task automatic inc(input logic [31:0] md, nx, input int n_exp, input logic [31:0] epc);
    bus(1'b1, `IOIE_ADR_CTRL, 32'h0);
    bus(1'b1, `IOIE_ADR_PC, 32'h100);
    bus(1'b1, `IOIE_ADR_MADDR, 32'h20);
    bus(1'b1, `IOIE_ADR_MDATA, md);
    bus(1'b1, `IOIE_ADR_NEXT, nx);
    ex(32'h4a20, n_exp);
    rdc(`IOIE_ADR_PC, epc, "pc");
  endtask

  // Watchdog: the sequence needs well under 2000 cycles
  initial begin
    #(40 * 4000);
    n_fail++;
    close_out();
  end

  initial begin
    repeat (6) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    // Reset values and an unmapped offset
    rdc(`IOIE_ADR_PC, 32'h0, "pc");
    rdc(`IOIE_ADR_STATUS, 32'h0, "status");
    bus(1'b1, 8'h30, 32'hffffffff);
    rdc(8'h30, 32'h0, "unmapped");
    // Literal OR; unrelated status bits must survive
    bus(1'b1, `IOIE_ADR_STATUS, 32'h0b);
    bus(1'b1, `IOIE_ADR_ACC, 32'h9a);
    ex(32'h0935, 4);
    rdc(`IOIE_ADR_ACC, 32'hbf, "acc");
    rdc(`IOIE_ADR_STATUS, 32'h1b, "status");
    rdc(`IOIE_ADR_PC, 32'h2, "pc");
    rdc(`IOIE_ADR_STATE, 32'h0, "state");
    bus(1'b1, `IOIE_ADR_ACC, 32'h0);
    ex(32'h0900, 4);
    rdc(`IOIE_ADR_STATUS, 32'h0f, "status");
    // File OR: destination, bank, access split, indexed boundary
    orf(0, 32'h310, 32'h13, 32'h91, 32'h1110, 32'h13, 32'h93);
    orf(0, 32'h310, 32'h13, 32'h40, 32'h1310, 32'h53, 32'h40);
    orf(0, 32'hf70, 32'h01, 32'h02, 32'h1270, 32'h03, 32'h02);
    orf(1, 32'h25f, 32'h80, 32'h01, 32'h125f, 32'h81, 32'h01);
    orf(1, 32'hf60, 32'h08, 32'h01, 32'h1260, 32'h09, 32'h01);
    orf(1, 32'h305, 32'h10, 32'h01, 32'h1305, 32'h11, 32'h01);
    rdc(`IOIE_ADR_STATUS, 32'h0b, "status");
    // Increment and skip: zero, one-word and two-word next
    inc(32'hff, 32'h0, 4, 32'h102);
    inc(32'h05, 32'h0, 8, 32'h104);
    inc(32'h05, 32'hef00, 12, 32'h106);
    close_out();
  end
endmodule // tb_ioie_core
`default_nettype wire
